/* File: logic/tiv_pkg.sv */
// Package with register map, field positions and timing constants of the timer block
package tiv_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned FAST_HZ = 16_000_000;
  localparam int unsigned MID_HZ = 4_000_000;
  localparam int unsigned SLOW_HZ = 32_768;
  localparam int unsigned ACC_W = 26;
  localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_HZ);
  localparam logic [ACC_W-1:0] ACC_FAST = ACC_W'(FAST_HZ);
  localparam logic [ACC_W-1:0] ACC_MID = ACC_W'(MID_HZ);
  localparam logic [ACC_W-1:0] ACC_SLOW = ACC_W'(SLOW_HZ);
  // Slow ticks per wake step: 2 s / 256 and 256 s / 256
  localparam logic [23:0] WAKE_STEP_SHORT = 24'h000100;
  localparam logic [23:0] WAKE_STEP_LONG = 24'h008000;
  localparam logic [7:0] A_GPT_CTRL = 8'h00;
  localparam logic [7:0] A_GPT_RELOAD = 8'h04;
  localparam logic [7:0] A_GPT_PWM = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0C;
  localparam logic [7:0] A_CTR_CTRL = 8'h10;
  localparam logic [7:0] A_CTR0 = 8'h14;
  localparam logic [7:0] A_CTR1 = 8'h18;
  localparam logic [7:0] A_GPT_CNT = 8'h1C;
  localparam logic [7:0] A_WAKE = 8'h20;
  localparam logic [7:0] A_IRQ_EN = 8'h24;
  localparam logic [7:0] A_IRQ_CFG = 8'h28;
  localparam logic [7:0] A_IRQ_ACK = 8'h2C;
  // Status bits
  localparam int ST_GPT = 0;
  localparam int ST_CTR0 = 1;
  localparam int ST_CTR1 = 2;
  localparam int ST_WAKE = 3;
  // Counter mode encodings
  localparam logic [1:0] M_13BIT = 2'h0;
  localparam logic [1:0] M_16BIT = 2'h1;
  localparam logic [1:0] M_RELOAD8 = 2'h2;
  localparam int NVEC = 15;
  localparam logic [3:0] V_EXT_A = 4'h0;
  localparam logic [3:0] V_CTR0 = 4'h1;
  localparam logic [3:0] V_EXT_B = 4'h2;
  localparam logic [3:0] V_CTR1 = 4'h3;
  localparam logic [3:0] V_GPT = 4'h7;
  localparam logic [3:0] V_NMI = 4'hE;
  // Fixed priority per vector, lower value wins
  localparam logic [3:0] PRIO [NVEC] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
    4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'h0};
  typedef enum logic [1:0] {
    PWM_HIGH = 2'b01,
    PWM_LOW = 2'b10
  } tiv_pwm_e;
endpackage : tiv_pkg

/* File: logic/tiv_timers.sv */
// Timers, sleep wake timer and fixed priority interrupt controller behind APB
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tiv_timers
  import tiv_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_request_line_a,
  input wire logic ext_request_line_b,
  input wire logic [7:0] port1_pins,
  input wire logic port3_bit4_pin,
  input wire logic port3_bit5_pin,
  input wire logic mains_zero_cross_input,
  input wire logic [NVEC-1:0] periph_req,
  output logic port3_bit7_pin,
  output logic wake_event,
  output logic irq_req,
  output logic [3:0] irq_vector
);

  function automatic logic [ACC_W:0] acc_step(input logic [ACC_W-1:0] acc,
                                               input logic [ACC_W-1:0] inc);
    logic [ACC_W:0] s;
    s = {1'b0, acc} + {1'b0, inc};
    if (s >= {1'b0, ACC_MOD}) begin
      acc_step = {1'b1, ACC_W'(s - {1'b0, ACC_MOD})};
    end else begin
      acc_step = {1'b0, s[ACC_W-1:0]};
    end
  endfunction : acc_step

  // Returns {overflow, next value} for the classic counter modes
  function automatic logic [16:0] ctr_step(input logic [1:0] mode, input logic [15:0] c);
    logic [16:0] r;
    r = {1'b0, c};
    case (mode)
      M_13BIT: begin
        if (c[4:0] == 5'h1F) begin
          r = {(c[15:8] == 8'hFF), c[15:8] + 8'h01, 3'h0, 5'h00};
        end else begin
          r = {1'b0, c[15:5], c[4:0] + 5'h01};
        end
      end
      M_16BIT: r = {1'b0, c} + 17'h00001;
      M_RELOAD8: begin
        if (c[7:0] == 8'hFF) begin
          r = {1'b1, c[15:8], c[15:8]};
        end else begin
          r = {1'b0, c[15:8], c[7:0] + 8'h01};
        end
      end
      default: r = {1'b0, c};
    endcase
    ctr_step = r;
  endfunction : ctr_step

  // Three stage synchronisers; a change counts once stages two and three agree
  logic [12:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Pulled-up idle level, so no false edge follows reset
      pin_s1_q <= '1;
      pin_s2_q <= '1;
      pin_s3_q <= '1;
      pin_q <= '1;
    end else begin
      pin_s1_q <= {mains_zero_cross_input, port3_bit5_pin, port3_bit4_pin,
                   ext_request_line_b, ext_request_line_a, port1_pins};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int i = 0; i < 13; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_q[i] <= pin_s3_q[i];
        end
      end
    end
  end
  logic [12:0] pin_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_q <= '1;
    end else begin
      pin_prev_q <= pin_q;
    end
  end
  logic ev0_fall, ev1_fall, zc_edge;
  assign ev0_fall = pin_prev_q[10] & ~pin_q[10];
  assign ev1_fall = pin_prev_q[11] & ~pin_q[11];
  assign zc_edge = pin_prev_q[12] ^ pin_q[12];

  // Tick generators derived from pclk, so the wake timer stays locked to it
  logic [ACC_W-1:0] acc_fast_q, acc_mid_q, acc_slow_q;
  logic [ACC_W:0] nf, nm, ns;
  logic tick_fast, tick_mid, tick_slow;
  assign nf = acc_step(acc_fast_q, ACC_FAST);
  assign nm = acc_step(acc_mid_q, ACC_MID);
  assign ns = acc_step(acc_slow_q, ACC_SLOW);
  assign tick_fast = nf[ACC_W];
  assign tick_mid = nm[ACC_W];
  assign tick_slow = ns[ACC_W];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_fast_q <= '0;
      acc_mid_q <= '0;
      acc_slow_q <= '0;
    end else begin
      acc_fast_q <= nf[ACC_W-1:0];
      acc_mid_q <= nm[ACC_W-1:0];
      acc_slow_q <= ns[ACC_W-1:0];
    end
  end

  // APB decode; one wait-free access cycle after setup
  logic wr, rd;
  assign wr = psel & penable & pwrite & pready;
  assign rd = psel & penable & ~pwrite & pready;
  logic mapped;
  always_comb begin
    case (paddr)
      A_GPT_CTRL, A_GPT_RELOAD, A_GPT_PWM, A_STATUS, A_CTR_CTRL, A_CTR0, A_CTR1,
      A_GPT_CNT, A_WAKE, A_IRQ_EN, A_IRQ_CFG, A_IRQ_ACK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  logic [3:0] gpt_ctrl_q;
  logic [15:0] gpt_reload_q, gpt_cnt_q, gpt_pwm_q;
  logic [7:0] ctr_ctrl_q;
  logic [9:0] wake_cfg_q;
  logic [NVEC-1:0] irq_en_q;
  logic [9:0] irq_cfg_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpt_ctrl_q <= '0;
      gpt_reload_q <= '0;
      gpt_pwm_q <= '0;
      ctr_ctrl_q <= '0;
      wake_cfg_q <= '0;
      irq_en_q <= '0;
      irq_cfg_q <= '0;
    end else if (wr) begin
      case (paddr)
        A_GPT_CTRL: gpt_ctrl_q <= pwdata[3:0];
        A_GPT_RELOAD: gpt_reload_q <= pwdata[15:0];
        A_GPT_PWM: gpt_pwm_q <= pwdata[15:0];
        A_CTR_CTRL: ctr_ctrl_q <= pwdata[7:0];
        A_WAKE: wake_cfg_q <= pwdata[9:0];
        A_IRQ_EN: irq_en_q <= pwdata[NVEC-1:0];
        A_IRQ_CFG: irq_cfg_q <= pwdata[9:0];
        default: ;
      endcase
    end
  end
  logic gpt_run, gpt_slow, gpt_irq_en, pwm_en;
  assign gpt_run = gpt_ctrl_q[0];
  assign gpt_slow = gpt_ctrl_q[1];
  assign gpt_irq_en = gpt_ctrl_q[2];
  assign pwm_en = gpt_ctrl_q[3];

  // General purpose timer
  logic gpt_tick, gpt_wrap;
  assign gpt_tick = gpt_run & (gpt_slow ? tick_slow : tick_mid);
  assign gpt_wrap = gpt_tick & (gpt_cnt_q == 16'hFFFF);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpt_cnt_q <= '0;
    end else if (wr && paddr == A_GPT_CNT) begin
      gpt_cnt_q <= pwdata[15:0];
    end else if (gpt_wrap) begin
      gpt_cnt_q <= gpt_reload_q;
    end else if (gpt_tick) begin
      gpt_cnt_q <= gpt_cnt_q + 16'h0001;
    end
  end

  // PWM phases count timer ticks; a zero length phase still lasts one tick, and a zero high length keeps the output low
  tiv_pwm_e pwm_st_q;
  logic [7:0] pwm_cnt_q;
  logic pwm_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_st_q <= PWM_HIGH;
      pwm_cnt_q <= '0;
      pwm_q <= 1'b0;
    end else begin
      if (!pwm_en) begin
        pwm_st_q <= PWM_HIGH;
        pwm_cnt_q <= '0;
      end else if (gpt_tick) begin
        case (pwm_st_q)
          PWM_HIGH: begin
            if (pwm_cnt_q + 8'h01 >= gpt_pwm_q[7:0]) begin
              pwm_st_q <= PWM_LOW;
              pwm_cnt_q <= '0;
            end else begin
              pwm_cnt_q <= pwm_cnt_q + 8'h01;
            end
          end
          PWM_LOW: begin
            if (pwm_cnt_q + 8'h01 >= gpt_pwm_q[15:8]) begin
              pwm_st_q <= PWM_HIGH;
              pwm_cnt_q <= '0;
            end else begin
              pwm_cnt_q <= pwm_cnt_q + 8'h01;
            end
          end
          default: pwm_st_q <= PWM_HIGH;
        endcase
      end
      pwm_q <= pwm_en & (pwm_st_q == PWM_HIGH) & (gpt_pwm_q[7:0] != 8'h00);
    end
  end

  // Counters zero and one; no gate input exists, run bit alone enables
  logic [15:0] ctr_q [2];
  logic [1:0] ctr_ovf;
  logic [1:0] ctr_inc;
  logic [16:0] cs0, cs1;
  assign ctr_inc[0] = ctr_ctrl_q[3] & (ctr_ctrl_q[2] ? ev0_fall : tick_fast);
  assign ctr_inc[1] = ctr_ctrl_q[7] & (ctr_ctrl_q[6] ? ev1_fall : tick_fast);
  assign cs0 = ctr_step(ctr_ctrl_q[1:0], ctr_q[0]);
  assign cs1 = ctr_step(ctr_ctrl_q[5:4], ctr_q[1]);
  assign ctr_ovf[0] = ctr_inc[0] & cs0[16];
  assign ctr_ovf[1] = ctr_inc[1] & cs1[16];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctr_q[0] <= '0;
      ctr_q[1] <= '0;
    end else begin
      if (wr && paddr == A_CTR0) begin
        ctr_q[0] <= pwdata[15:0];
      end else if (ctr_inc[0]) begin
        ctr_q[0] <= cs0[15:0];
      end
      if (wr && paddr == A_CTR1) begin
        ctr_q[1] <= pwdata[15:0];
      end else if (ctr_inc[1]) begin
        ctr_q[1] <= cs1[15:0];
      end
    end
  end

  // Wake timer: value times step, step set by range; arming restarts it
  logic [23:0] wake_cnt_q;
  logic [23:0] wake_target;
  logic wake_arm_q, wake_hit;
  assign wake_target = 24'(wake_cfg_q[7:0]) * (wake_cfg_q[8] ? WAKE_STEP_LONG
                                                              : WAKE_STEP_SHORT);
  assign wake_hit = wake_arm_q & (wake_cnt_q >= wake_target);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cnt_q <= '0;
      wake_arm_q <= 1'b0;
      wake_event <= 1'b0;
    end else begin
      wake_event <= wake_hit;
      if (wr && paddr == A_WAKE) begin
        wake_cnt_q <= '0;
        wake_arm_q <= pwdata[9];
      end else if (wake_hit) begin
        wake_arm_q <= 1'b0;
      end else if (wake_arm_q && tick_slow) begin
        wake_cnt_q <= wake_cnt_q + 24'h000001;
      end
    end
  end

  // Sticky status flags, write one to clear; a new event wins over the clear
  logic [3:0] stat_q;
  logic [3:0] stat_set, stat_clr;
  logic ack_wr;
  assign ack_wr = wr && paddr == A_IRQ_ACK;
  assign stat_set = {wake_hit, ctr_ovf, gpt_wrap};
  always_comb begin
    stat_clr = '0;
    if (wr && paddr == A_STATUS) begin
      stat_clr = pwdata[3:0];
    end
    if (ack_wr) begin
      stat_clr[ST_GPT] = stat_clr[ST_GPT] | (pwdata[3:0] == V_GPT);
      stat_clr[ST_CTR0] = stat_clr[ST_CTR0] | (pwdata[3:0] == V_CTR0);
      stat_clr[ST_CTR1] = stat_clr[ST_CTR1] | (pwdata[3:0] == V_CTR1);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_set | (stat_q & ~stat_clr);
    end
  end

  // Interrupt sources; external lines and peripheral requests are levels
  logic ext_a, ext_b, p1_low;
  logic [NVEC-1:0] src, pend;
  assign ext_a = pin_q[8] ^ irq_cfg_q[8];
  assign ext_b = pin_q[9] ^ irq_cfg_q[9];
  assign p1_low = |(~pin_q[7:0] & irq_cfg_q[7:0]);
  always_comb begin
    src = periph_req;
    src[V_EXT_A] = ext_a | periph_req[V_EXT_A];
    src[V_CTR0] = stat_q[ST_CTR0];
    src[V_EXT_B] = ext_b | p1_low | periph_req[V_EXT_B];
    src[V_CTR1] = stat_q[ST_CTR1];
    src[6] = zc_edge | periph_req[6];
    src[V_GPT] = stat_q[ST_GPT] & gpt_irq_en;
  end

  // Zero-cross is an edge, so it is latched until acknowledged
  logic zc_pend_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zc_pend_q <= 1'b0;
    end else begin
      zc_pend_q <= zc_edge | (zc_pend_q & ~(ack_wr && pwdata[3:0] == 4'h6));
    end
  end

  always_comb begin
    pend = (src | {8'h00, zc_pend_q, 6'h00}) & irq_en_q;
    pend[V_NMI] = src[V_NMI];
  end

  // Fixed table scan; lowest priority value wins, rest stay pending
  logic found;
  logic [3:0] best_v, best_p;
  always_comb begin
    found = 1'b0;
    best_v = '0;
    best_p = '1;
    for (int i = 0; i < NVEC; i++) begin
      if (pend[i] && (!found || PRIO[i] < best_p)) begin
        found = 1'b1;
        best_v = 4'(i);
        best_p = PRIO[i];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 1'b0;
      irq_vector <= '0;
    end else begin
      irq_req <= found;
      irq_vector <= best_v;
    end
  end

  // APB answer: pready one cycle after setup, error on unmapped address
  logic [31:0] rdata;
  always_comb begin
    case (paddr)
      A_GPT_CTRL: rdata = {28'h0, gpt_ctrl_q};
      A_GPT_RELOAD: rdata = {16'h0, gpt_reload_q};
      A_GPT_PWM: rdata = {16'h0, gpt_pwm_q};
      A_STATUS: rdata = {28'h0, stat_q};
      A_CTR_CTRL: rdata = {24'h0, ctr_ctrl_q};
      A_CTR0: rdata = {16'h0, ctr_q[0]};
      A_CTR1: rdata = {16'h0, ctr_q[1]};
      A_GPT_CNT: rdata = {16'h0, gpt_cnt_q};
      A_WAKE: rdata = {22'h0, wake_arm_q, wake_cfg_q[8:0]};
      A_IRQ_EN: rdata = {17'h0, irq_en_q};
      A_IRQ_CFG: rdata = {22'h0, irq_cfg_q};
      A_IRQ_ACK: rdata = {11'h000, pend, 1'b0, irq_req, irq_vector};
      default: rdata = '0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & ~mapped;
      // Read data stands for the access cycle only; writes show zero
      prdata <= (psel && !penable && !pwrite) ? rdata : '0;
    end
  end
  logic unused_rd;
  assign unused_rd = rd;
  assign port3_bit7_pin = pwm_q;

endmodule : tiv_timers
`default_nettype wire

/* File: testbench/tiv_timers_chk.sv */
// Port assertions for the timer and interrupt block
`timescale 1ns/1ps
`default_nettype none
module tiv_chk
  import tiv_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NVEC-1:0] periph_req,
  input wire logic wake_event,
  input wire logic irq_req,
  input wire logic [3:0] irq_vector
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_idle2; !psel [*2]; endsequence
  sequence s_nmi_held; periph_req[14] [*3]; endsequence
  property p_ready_after_setup; s_setup |=> pready; endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_ready_cause; pready |-> $past(psel) && !$past(penable); endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
  property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused access leaks data");
  property p_nmi_wins; s_nmi_held |-> irq_req && irq_vector == V_NMI; endproperty
  a_nmi_wins: assert property (p_nmi_wins) else $error("held NMI not presented");
  property p_nmi_cause;
    irq_req && irq_vector == V_NMI |->
      $past(periph_req[14]) || $past(periph_req[14], 2) || $past(periph_req[14], 3);
  endproperty
  a_nmi_cause: assert property (p_nmi_cause) else $error("NMI vector without request");
  property p_vec_range; irq_req |-> irq_vector != 4'hF; endproperty
  a_vec_range: assert property (p_vec_range) else $error("vector out of range");
  property p_wake_pulse; wake_event |=> !wake_event; endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
  // A wrap flag only goes away through the bus, so a quiet bus keeps it up
  property p_gpt_holds; s_idle2 ##0 (irq_req && irq_vector == V_GPT) |=> irq_req; endproperty
  a_gpt_holds: assert property (p_gpt_holds) else $error("timer request lost");
endmodule : tiv_chk
bind tiv_timers tiv_chk tiv_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .periph_req(periph_req), .wake_event(wake_event),
  .irq_req(irq_req), .irq_vector(irq_vector));
`default_nettype wire

/* File: testbench/tiv_core_model.sv */
// Processor core model that takes the presented interrupt vector
`timescale 1ns/1ps
`default_nettype none
module tiv_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_req,
  input wire logic [3:0] irq_vector,
  output logic [3:0] svc_vec
);
  // Latches the vector it would jump to; acknowledge goes through the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      svc_vec <= 4'hF;
    end else if (irq_req) begin
      svc_vec <= irq_vector;
    end
  end
endmodule : tiv_core_model
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the timer and interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tiv_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic line_a = 1'b0;
  logic line_b = 1'b0;
  logic p34 = 1'b1;
  logic p35 = 1'b1;
  logic zc = 1'b1;
  logic [7:0] p1 = 8'hFF;
  logic [NVEC-1:0] preq = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, pwm, wake, irq_req, err;
  logic [3:0] irq_vector, svc_vec;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #10 pclk = ~pclk;
  tiv_timers tiv_timers_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_request_line_a(line_a), .ext_request_line_b(line_b),
    .port1_pins(p1), .port3_bit4_pin(p34), .port3_bit5_pin(p35),
    .mains_zero_cross_input(zc), .periph_req(preq), .port3_bit7_pin(pwm),
    .wake_event(wake), .irq_req(irq_req), .irq_vector(irq_vector));
  tiv_core_model tiv_core_model_inst (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
    .irq_vector(irq_vector), .svc_vec(svc_vec));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_irq(input logic [3:0] v, input int lim, output int took);
    took = 0;
    while (!(irq_req === 1'b1 && irq_vector === v) && took < lim) begin
      @(posedge pclk);
      took++;
    end
  endtask : wait_irq
  task automatic conclude;
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      conclude();
    end
  end
  initial begin : main
    int t;
    int hi;
    int lo;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, A_IRQ_EN, 32'h0000_7FFF);
    apb(1'b0, A_IRQ_EN, 32'h0);
    chk(rd, 32'h0000_7FFF);
    $display("test registers done");
    // Sixteen ticks of 4 MHz from 0xFFF0 to the wrap is 200 clocks
    apb(1'b1, A_GPT_RELOAD, 32'h0000_FFF0);
    apb(1'b1, A_GPT_CNT, 32'h0000_FFF0);
    apb(1'b1, A_GPT_CTRL, 32'h0000_0005);
    wait_irq(V_GPT, 400, t);
    chk({28'h0, irq_vector}, {28'h0, V_GPT});
    chk(32'(t > 150 && t < 260), 32'h1);
    apb(1'b0, A_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    chk({28'h0, svc_vec}, 32'h7);
    apb(1'b1, A_GPT_CTRL, 32'h0);
    apb(1'b1, A_IRQ_ACK, 32'h7);
    repeat (4) @(posedge pclk);
    chk({31'h0, irq_req}, 32'h0);
    $display("test timer done");
    apb(1'b1, A_IRQ_EN, 32'h0);
    preq[14] <= 1'b1;
    wait_irq(V_NMI, 10, t);
    chk({28'h0, irq_vector}, 32'hE);
    line_a <= 1'b1;
    apb(1'b1, A_IRQ_EN, 32'h1);
    repeat (8) @(posedge pclk);
    chk({28'h0, irq_vector}, 32'hE);
    preq[14] <= 1'b0;
    wait_irq(V_EXT_A, 10, t);
    chk({27'h0, irq_req, irq_vector}, 32'h10);
    apb(1'b1, A_IRQ_CFG, 32'h0000_0100);
    repeat (8) @(posedge pclk);
    chk({31'h0, irq_req}, 32'h0);
    line_a <= 1'b0;
    wait_irq(V_EXT_A, 10, t);
    chk({31'h0, irq_req}, 32'h1);
    apb(1'b1, A_IRQ_CFG, 32'h1);
    apb(1'b1, A_IRQ_EN, 32'h4);
    p1[0] <= 1'b0;
    wait_irq(V_EXT_B, 10, t);
    chk({28'h0, irq_vector}, 32'h2);
    apb(1'b0, A_IRQ_ACK, 32'h0);
    chk(rd, 32'h0000_0112);
    p1[0] <= 1'b1;
    $display("test interrupts done");
    apb(1'b1, A_CTR0, 32'h0);
    apb(1'b1, A_CTR1, 32'h0);
    apb(1'b1, A_CTR_CTRL, 32'h0000_00DD);
    for (int i = 0; i < 5; i++) begin
      p34 <= 1'b0;
      p35 <= (i > 2);
      repeat (6) @(posedge pclk);
      p34 <= 1'b1;
      p35 <= 1'b1;
      repeat (6) @(posedge pclk);
    end
    apb(1'b0, A_CTR0, 32'h0);
    chk(rd & 32'hFFFF, 32'h5);
    apb(1'b0, A_CTR1, 32'h0);
    chk(rd & 32'hFFFF, 32'h3);
    // About 16 counts per 50 clocks, so near 32 over 100 clocks
    apb(1'b1, A_CTR0, 32'h0);
    apb(1'b1, A_CTR_CTRL, 32'h0000_0009);
    repeat (100) @(posedge pclk);
    apb(1'b0, A_CTR0, 32'h0);
    chk(32'(rd > 28 && rd < 40), 32'h1);
    apb(1'b1, A_CTR_CTRL, 32'h0);
    // Classic 13-bit and 8-bit reload modes, two events each
    apb(1'b1, A_CTR0, 32'h0000_001F);
    apb(1'b1, A_CTR1, 32'h0000_80FE);
    apb(1'b1, A_CTR_CTRL, 32'h0000_00EC);
    repeat (2) begin
      p34 <= 1'b0;
      p35 <= 1'b0;
      repeat (6) @(posedge pclk);
      p34 <= 1'b1;
      p35 <= 1'b1;
      repeat (6) @(posedge pclk);
    end
    apb(1'b0, A_CTR0, 32'h0);
    chk(rd, 32'h0000_0101);
    apb(1'b0, A_CTR1, 32'h0);
    chk(rd, 32'h0000_8080);
    apb(1'b0, A_STATUS, 32'h0);
    chk(rd & 32'h6, 32'h4);
    apb(1'b1, A_CTR_CTRL, 32'h0);
    $display("test counters done");
    apb(1'b1, A_GPT_PWM, 32'h0000_0C02);
    apb(1'b1, A_GPT_CTRL, 32'h0000_0009);
    hi = 0;
    lo = 0;
    repeat (1500) begin
      @(posedge pclk);
      if (pwm === 1'b1) hi++;
      else lo++;
    end
    chk(32'(hi > 0 && hi * 3 < lo), 32'h1);
    apb(1'b1, A_GPT_CTRL, 32'h0);
    $display("test pwm done");
    apb(1'b1, A_WAKE, 32'h0000_0200);
    t = 0;
    while (wake !== 1'b1 && t < 50) begin
      @(posedge pclk);
      t++;
    end
    chk({31'h0, wake}, 32'h1);
    $display("test wake done");
    apb(1'b1, A_IRQ_EN, 32'h40);
    zc <= 1'b0;
    wait_irq(4'h6, 10, t);
    chk({28'h0, irq_vector}, 32'h6);
    apb(1'b1, A_IRQ_ACK, 32'h6);
    repeat (4) @(posedge pclk);
    chk({31'h0, irq_req}, 32'h0);
    $display("test zero crossing done");
    conclude();
  end
endmodule : tb
`default_nettype wire
